// >>> shared/acpm_regs.vh
// Purpose: register offsets, field positions and reset values of the address and bus control port mux
// Assumes: eight-bit register port, byte offsets
// Notes:   definitions only
`ifndef ACPM_REGS_VH
`define ACPM_REGS_VH

// register port widths
`define ACPM_ADDR_W          5
`define ACPM_DATA_W          8

// offsets of the low address port
`define ACPM_OFF_LA_DATA     5'h0C
`define ACPM_OFF_LA_DIR      5'h0E
`define ACPM_OFF_LA_FUNC     5'h0F

// offsets of the bus control port
`define ACPM_OFF_BC_DATA     5'h0D
`define ACPM_OFF_BC_DIR      5'h10
`define ACPM_OFF_BC_FUNC     5'h11

// read-only block status
`define ACPM_OFF_STATUS      5'h12

// reset values
`define ACPM_RST_LA_DATA     8'h00
`define ACPM_RST_LA_DIR      8'h00
`define ACPM_RST_LA_FUNC     8'h00
`define ACPM_RST_BC_DATA     8'hFF
`define ACPM_RST_BC_DIR      8'h00
`define ACPM_RST_BC_FUNC     8'h80

// implemented bits of the bus control direction and function registers, and the output-only pins of the port
`define ACPM_BC_DIR_MASK     8'h7C
`define ACPM_BC_FUNC_MASK    8'h9F
`define ACPM_BC_OUT_ONLY     8'h83

// field positions in the bus control port
`define ACPM_BIT_RD          0
`define ACPM_BIT_WR          1
`define ACPM_BIT_WAIT        5
`define ACPM_BIT_EXTERNAL_INTERRUPT_ZERO        6
`define ACPM_BIT_CLOCK_OUTPUT_PIN      7

// field positions in the status register
`define ACPM_ST_CLOCK_OUTPUT_PIN       0
`define ACPM_ST_RD_N         1
`define ACPM_ST_WAIT_N       2
`define ACPM_ST_EXTERNAL_INTERRUPT_ZERO         3

`endif

// >>> design/acpm_pin_cell.v
// Purpose: one registered pad driver, choosing between latch data and an alternate function
// Assumes: single clock, synchronous active-high reset
// Notes:   output enable is active low, so a low enable means the pin is driven
`timescale 1ns/1ps
module acpm_pin_cell #(
   parameter RST_OUT  = 1'b0,
   parameter RST_OE_N = 1'b1
) (
   input  wire clk,
   input  wire srst,
   input  wire drive,
   input  wire fn_sel,
   input  wire fn_val,
   input  wire latch,
   output reg  pin_out_q,
   output reg  pin_oe_n_q
);

   // registered so that the pad never sees a combinational glitch
   always @(posedge clk) begin
      if (srst) begin
         pin_out_q  <= RST_OUT;
         pin_oe_n_q <= RST_OE_N;
      end else begin
         pin_out_q  <= fn_sel ? fn_val : latch;
         pin_oe_n_q <= ~drive;
      end
   end

endmodule // acpm_pin_cell

// >>> design/acpm_port_mux.v
// Purpose: pin-function logic for the low address port and the bus control port
// Assumes: all pin and core inputs are synchronous to clk (20 MHz)
// Notes:   direction and function registers are write-only and read back as zero;
//          write and bus acknowledge alternate functions are not modelled, those pins stay plain ports
`timescale 1ns/1ps
`include "acpm_regs.vh"

module acpm_port_mux (
   input  wire                     clk,
   input  wire                     srst,
   // register port
   input  wire [`ACPM_ADDR_W-1:0]  reg_addr,
   input  wire [`ACPM_DATA_W-1:0]  reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [`ACPM_DATA_W-1:0]  reg_rdata_q,
   // core bus side
   input  wire [7:0]               core_addr_lo,
   input  wire                     core_rd_cyc,
   input  wire                     core_ext_area,
   output reg                      core_wait_n_q,
   output reg                      core_external_interrupt_zero_q,
   // low address port pins
   input  wire [7:0]               la_pin_in,
   output wire [7:0]               la_pin_out,
   output wire [7:0]               la_pin_oe_n,
   // bus control port pins
   input  wire [7:0]               bc_pin_in,
   output wire [7:0]               bc_pin_out,
   output wire [7:0]               bc_pin_oe_n,
   output reg  [7:0]               bc_pullup_en_q
);

   // software-visible state
   reg  [7:0] la_data_q;
   reg  [7:0] la_dir_q;
   reg  [7:0] la_func_q;
   reg  [7:0] bc_data_q;
   reg  [7:0] bc_dir_q;
   reg  [7:0] bc_func_q;

   // generated signals
   reg        clock_output_pin_q;
   reg        rd_strobe_n_q;
   reg        rd_strobe_n_d;

   // per-pin drive decisions feeding the pad cells
   wire [7:0] la_drive;
   wire [7:0] la_fn_sel;
   wire [7:0] bc_drive;
   wire [7:0] bc_fn_sel;
   wire [7:0] bc_fn_val;

   // register write strobes
   wire       wr_la_data;
   wire       wr_la_dir;
   wire       wr_la_func;
   wire       wr_bc_data;
   wire       wr_bc_dir;
   wire       wr_bc_func;

   // pin readback: output pins show their latch, input pins show the pad
   function [7:0] pin_view;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pad;
      begin
         pin_view = (dir & latch) | (~dir & pad);
      end
   endfunction

   // write strobe for one register offset
   function reg_hit;
      input                    strobe;
      input [`ACPM_ADDR_W-1:0] addr;
      input [`ACPM_ADDR_W-1:0] offset;
      begin
         reg_hit = strobe & (addr == offset);
      end
   endfunction

   // address decode of the write port
   assign wr_la_data = reg_hit(reg_wr, reg_addr, `ACPM_OFF_LA_DATA);
   assign wr_la_dir  = reg_hit(reg_wr, reg_addr, `ACPM_OFF_LA_DIR);
   assign wr_la_func = reg_hit(reg_wr, reg_addr, `ACPM_OFF_LA_FUNC);
   assign wr_bc_data = reg_hit(reg_wr, reg_addr, `ACPM_OFF_BC_DATA);
   assign wr_bc_dir  = reg_hit(reg_wr, reg_addr, `ACPM_OFF_BC_DIR);
   assign wr_bc_func = reg_hit(reg_wr, reg_addr, `ACPM_OFF_BC_FUNC);

   // low address port registers; order of direction and function writes is up to software
   always @(posedge clk) begin
      if (srst) begin
         la_data_q <= `ACPM_RST_LA_DATA;
         la_dir_q  <= `ACPM_RST_LA_DIR;
         la_func_q <= `ACPM_RST_LA_FUNC;
      end else begin
         if (wr_la_data) begin
            la_data_q <= reg_wdata;
         end
         if (wr_la_dir) begin
            la_dir_q <= reg_wdata;
         end
         if (wr_la_func) begin
            la_func_q <= reg_wdata;
         end
      end
   end

   // bus control port registers; unimplemented bits are held at zero by masking
   always @(posedge clk) begin
      if (srst) begin
         bc_data_q <= `ACPM_RST_BC_DATA;
         bc_dir_q  <= `ACPM_RST_BC_DIR;
         bc_func_q <= `ACPM_RST_BC_FUNC;
      end else begin
         if (wr_bc_data) begin
            bc_data_q <= reg_wdata;
         end
         if (wr_bc_dir) begin
            bc_dir_q <= reg_wdata & `ACPM_BC_DIR_MASK;
         end
         if (wr_bc_func) begin
            bc_func_q <= reg_wdata & `ACPM_BC_FUNC_MASK;
         end
      end
   end

   // clock output: half the system clock, running from reset so pin 7 carries it at once
   always @(posedge clk) begin
      if (srst) begin
         clock_output_pin_q <= 1'b1;
      end else begin
         clock_output_pin_q <= ~clock_output_pin_q;
      end
   end

   // read strobe: latch bit 0 low strobes every read, high only external reads
   always @* begin
      rd_strobe_n_d = 1'b1;
      if (core_rd_cyc) begin
         if (!bc_data_q[`ACPM_BIT_RD]) begin
            rd_strobe_n_d = 1'b0;
         end else if (core_ext_area) begin
            rd_strobe_n_d = 1'b0;
         end
      end
   end

   // strobe kept as its own flop so the status register can report it
   always @(posedge clk) begin
      if (srst) begin
         rd_strobe_n_q <= 1'b1;
      end else begin
         rd_strobe_n_q <= rd_strobe_n_d;
      end
   end

   // wait and interrupt inputs reach the core only while their pin is an input
   always @(posedge clk) begin
      if (srst) begin
         core_wait_n_q <= 1'b1;
         core_external_interrupt_zero_q   <= 1'b0;
      end else begin
         core_wait_n_q <= bc_dir_q[`ACPM_BIT_WAIT] | bc_pin_in[`ACPM_BIT_WAIT];
         core_external_interrupt_zero_q   <= ~bc_dir_q[`ACPM_BIT_EXTERNAL_INTERRUPT_ZERO] & bc_pin_in[`ACPM_BIT_EXTERNAL_INTERRUPT_ZERO];
      end
   end

   // pull-ups follow the latch on input pins; output-only pins never need one
   always @(posedge clk) begin
      if (srst) begin
         bc_pullup_en_q <= `ACPM_RST_BC_DATA & ~`ACPM_BC_OUT_ONLY;
      end else begin
         bc_pullup_en_q <= ~bc_dir_q & bc_data_q & ~`ACPM_BC_OUT_ONLY;
      end
   end

   // low address port: address only when both direction and function bits are set
   assign la_drive  = la_dir_q;
   assign la_fn_sel = la_dir_q & la_func_q;

   // bus control port: output-only pins always drive, others follow their direction bit
   assign bc_drive  = bc_dir_q | `ACPM_BC_OUT_ONLY;
   assign bc_fn_sel = {bc_func_q[`ACPM_BIT_CLOCK_OUTPUT_PIN], 6'h00, bc_func_q[`ACPM_BIT_RD]};
   assign bc_fn_val = {clock_output_pin_q, 6'h00, rd_strobe_n_d};

   // pad cells: sixteen registered drivers, differing only in reset values
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pins
         acpm_pin_cell #(
            .RST_OUT  (1'b0),
            .RST_OE_N (1'b1)
         ) u_la_cell (
            .clk        (clk),
            .srst       (srst),
            .drive      (la_drive[gi]),
            .fn_sel     (la_fn_sel[gi]),
            .fn_val     (core_addr_lo[gi]),
            .latch      (la_data_q[gi]),
            .pin_out_q  (la_pin_out[gi]),
            .pin_oe_n_q (la_pin_oe_n[gi])
         );
         acpm_pin_cell #(
            .RST_OUT  (1'b1),
            .RST_OE_N (((`ACPM_BC_OUT_ONLY >> gi) & 8'h01) == 8'h00)
         ) u_bc_cell (
            .clk        (clk),
            .srst       (srst),
            .drive      (bc_drive[gi]),
            .fn_sel     (bc_fn_sel[gi]),
            .fn_val     (bc_fn_val[gi]),
            .latch      (bc_data_q[gi]),
            .pin_out_q  (bc_pin_out[gi]),
            .pin_oe_n_q (bc_pin_oe_n[gi])
         );
      end
   endgenerate

   // read port: data one cycle after the strobe, write-only and unmapped offsets read zero
   always @(posedge clk) begin
      if (srst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ACPM_OFF_LA_DATA: begin
               reg_rdata_q <= pin_view(la_dir_q, la_data_q, la_pin_in);
            end
            `ACPM_OFF_BC_DATA: begin
               reg_rdata_q <= pin_view(bc_drive, bc_data_q, bc_pin_in);
            end
            `ACPM_OFF_STATUS: begin
               reg_rdata_q <= {4'h0, core_external_interrupt_zero_q, core_wait_n_q, rd_strobe_n_q, clock_output_pin_q};
            end
            default: begin
               reg_rdata_q <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

endmodule // acpm_port_mux

// >>> verif/acpm_props_properties.sv
// Purpose: pin and register port assertions for the port mux
// Assumes: single clock, srst synchronous active high
// Notes:   sees top ports only, bound from the bench top
`timescale 1ns/1ps
module acpm_props (
   input wire       clk,
   input wire       srst,
   input wire [4:0] reg_addr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata_q,
   input wire       core_wait_n_q,
   input wire       core_external_interrupt_zero_q,
   input wire [7:0] la_pin_out,
   input wire [7:0] la_pin_oe_n,
   input wire [7:0] bc_pin_in,
   input wire [7:0] bc_pin_out,
   input wire [7:0] bc_pin_oe_n,
   input wire [7:0] bc_pullup_en_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // output-only pins always driven; pull-ups only on released pins, so a driven pin never fights its own resistor
   out_only_a: assert property ((bc_pin_oe_n & 8'h83) == 8'h00)
      else $error("output-only pin released");
   pullup_input_a: assert property ((bc_pullup_en_q & ~bc_pin_oe_n) == 8'h00)
      else $error("pull-up on driven pin");
   // wait and interrupt levels lag their pad by one edge
   wait_fwd_a: assert property (!$past(srst) |-> core_wait_n_q == (!bc_pin_oe_n[5] | $past(bc_pin_in[5])))
      else $error("wait level wrong");
   external_interrupt_zero_fwd_a: assert property (!$past(srst) |-> core_external_interrupt_zero_q == (bc_pin_oe_n[6] & $past(bc_pin_in[6])))
      else $error("interrupt level wrong");
   // reset state seen at the first edge after release
   la_reset_a: assert property ($past(srst) |-> la_pin_oe_n == 8'hFF && la_pin_out == 8'h00)
      else $error("low address pins not reset");
   bc_reset_a: assert property ($past(srst) |-> bc_pin_out == 8'hFF && bc_pullup_en_q == 8'h7C)
      else $error("bus control pins not reset");
   clk_out_a: assert property ($fell(srst) |-> ##2 bc_pin_out[7] != $past(bc_pin_out[7]))
      else $error("clock output not toggling");
   // read data stand one cycle only; write-only places read nothing
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
      else $error("read data outside read slot");
   rdata_wo_a: assert property ($past(reg_rd) && $past(reg_addr) inside {5'h0E, 5'h0F, 5'h10, 5'h11}
      |-> reg_rdata_q == 8'h00) else $error("write-only register read back");
endmodule // acpm_props

// >>> verif/acpm_pad_model.sv
// Purpose: pads and outside parts attached to one port
// Assumes: outside parts drive only where ext_en is set
// Notes:   an undriven pin without pull-up floats, shown as a toggling level
`timescale 1ns/1ps
module acpm_pad_model (
   input  wire       clk,
   input  wire [7:0] out,
   input  wire [7:0] oe_n,
   input  wire [7:0] pu,
   input  wire [7:0] ext,
   input  wire [7:0] ext_en,
   output wire [7:0] lvl
);
   reg [7:0] flt_q = 8'h55;
   // a floating pin must never look stable to the design
   always @(posedge clk) begin
      flt_q <= ~flt_q;
   end
   // device drive wins, then an outside driver, then the pull-up
   assign lvl = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pu | flt_q));
endmodule // acpm_pad_model

// >>> verif/acpm_port_mux_tb_top.sv
// Purpose: self-checking bench for the address and bus control port mux
// Assumes: 20 MHz clock, srst held 12 cycles
// Notes:   outside parts drive all released pins, so pad reads are predictable
`timescale 1ns/1ps
module acpm_port_mux_tb_top;
   reg        clk, srst, reg_wr, reg_rd, core_rd_cyc, core_ext_area;
   reg  [4:0] reg_addr;
   reg  [7:0] reg_wdata, core_addr_lo, la_ext, bc_ext, d, f, l, a, m, rv;
   wire [7:0] reg_rdata_q, la_pin_in, la_pin_out, la_pin_oe_n;
   wire [7:0] bc_pin_in, bc_pin_out, bc_pin_oe_n, bc_pullup_en_q;
   wire       core_wait_n_q, core_external_interrupt_zero_q;
   integer    failures, n_compared, i;

   acpm_port_mux u_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .core_addr_lo, .core_rd_cyc, .core_ext_area, .core_wait_n_q, .core_external_interrupt_zero_q, .la_pin_in,
      .la_pin_out, .la_pin_oe_n, .bc_pin_in, .bc_pin_out, .bc_pin_oe_n, .bc_pullup_en_q);
   acpm_pad_model u_la_pads (.clk, .out(la_pin_out), .oe_n(la_pin_oe_n), .pu(8'h00), .ext(la_ext),
      .ext_en(8'hFF), .lvl(la_pin_in));
   acpm_pad_model u_bc_pads (.clk, .out(bc_pin_out), .oe_n(bc_pin_oe_n), .pu(bc_pullup_en_q),
      .ext(bc_ext), .ext_en(8'h7C), .lvl(bc_pin_in));

   // register port cycles, one strobe cycle each
   task wr(input [4:0] ad, input [7:0] wd);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= wd;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [4:0] ad);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rv = reg_rdata_q;
   endtask
   // a write reaches the pads two edges on; one more for margin
   task settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] s);
      n_compared = n_compared + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task rst_chk;
      srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("bc_pullup", 8'h7C, bc_pullup_en_q);
      chk("bc_oe_n", 8'h7C, bc_pin_oe_n);
      chk("bc_out", 8'h7F, bc_pin_out & 8'h7F);
      chk("la_oe_n", 8'hFF, la_pin_oe_n);
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // main sequence
   initial begin
      {srst, reg_wr, reg_rd, core_rd_cyc, core_ext_area} = 5'h10;
      reg_addr = 5'h00;
      {reg_wdata, core_addr_lo, la_ext, bc_ext} = 32'h0;
      failures = 0;
      n_compared = 0;
      void'($urandom(32'hF281));
      rst_chk;
      // function bits clear at reset, so direction alone must not expose the address
      wr(5'h0E, 8'hFF);
      core_addr_lo <= 8'hA5;
      settle;
      chk("la_out", 8'h00, la_pin_out);
      for (i = 0; i < 5; i = i + 1) begin
         rd((i == 4) ? 5'h1F : 5'h0E + i[4:0]);
         chk("wo_read", 8'h00, rv);
      end
      // low address port, random masks
      for (i = 0; i < 8; i = i + 1) begin
         {d, f, l, a} = $urandom;
         if (i == 0) {d, f} = 16'hFFFF;
         wr(5'h0C, l);
         wr(5'h0E, d);
         wr(5'h0F, f);
         core_addr_lo <= a;
         la_ext <= ~a;
         settle;
         chk("la_out", (d & f & a) | (~(d & f) & l), la_pin_out);
         chk("la_oe_n", ~d, la_pin_oe_n);
         rd(5'h0C);
         chk("la_read", (d & l) | (~d & ~a), rv);
      end
      // bus control port with no read cycles running
      for (i = 0; i < 8; i = i + 1) begin
         {d, f, l, a} = $urandom;
         m = (d & 8'h7C) | 8'h83;
         wr(5'h0D, l);
         wr(5'h10, d);
         wr(5'h11, f & 8'h7F);
         bc_ext <= a;
         settle;
         chk("bc_oe_n", ~m, bc_pin_oe_n);
         chk("bc_out", {l[7:1], l[0] | f[0]}, bc_pin_out);
         chk("bc_pullup", ~m & l, bc_pullup_en_q);
         chk("wait_n", {7'h0, m[5] | a[5]}, {7'h0, core_wait_n_q});
         chk("external_interrupt_zero", {7'h0, ~m[6] & a[6]}, {7'h0, core_external_interrupt_zero_q});
         rd(5'h0D);
         chk("bc_read", (l & m) | (a & ~m), rv);
      end
      // every mix of select, latch bit, read cycle and area
      for (i = 0; i < 16; i = i + 1) begin
         wr(5'h0D, {7'h7F, i[2]});
         wr(5'h11, {7'h40, i[3]});
         core_rd_cyc <= i[1];
         core_ext_area <= i[0];
         settle;
         chk("strobe", {7'h0, i[3] ? ~(i[1] & (~i[2] | i[0])) : i[2]}, {7'h0, bc_pin_out[0]});
         // status shows the strobe flop whatever the select; clock bit masked as it never stands
         rd(5'h12);
         chk("status", {4'h0, ~m[6] & a[6], m[5] | a[5], ~(i[1] & (~i[2] | i[0])), 1'b0}, rv & 8'hFE);
      end
      // core inputs change only just after a rising edge
      @(posedge clk);
      core_rd_cyc <= 1'b0;
      core_ext_area <= 1'b0;
      @(negedge clk);
      rv = {7'h0, bc_pin_out[7]};
      @(negedge clk);
      chk("clk_out", ~rv & 8'h01, {7'h0, bc_pin_out[7]});
      // second reset in mid-run, raised just after a rising edge like every other input
      @(posedge clk);
      rst_chk;
      wrap_up;
   end
endmodule // acpm_port_mux_tb_top

bind acpm_port_mux acpm_props u_chk (.clk, .srst, .reg_addr, .reg_rd, .reg_rdata_q, .core_wait_n_q,
   .core_external_interrupt_zero_q, .la_pin_out, .la_pin_oe_n, .bc_pin_in, .bc_pin_out, .bc_pin_oe_n, .bc_pullup_en_q);
